//--- core/gac_axil_slave.v
`default_nettype none
`include "gac_consts.vh"

// AXI4-Lite slave write front end: takes address and data in either order.
module gac_axil_slave
(
	input  wire        clk_sys_i,
	input  wire        srst_i,
	input  wire [5:0]  s_axi_awaddr_i,
	input  wire        s_axi_awvalid_i,
	output reg         s_axi_awready_o,
	input  wire [31:0] s_axi_wdata_i,
	input  wire [3:0]  s_axi_wstrb_i,
	input  wire        s_axi_wvalid_i,
	output reg         s_axi_wready_o,
	output reg  [1:0]  s_axi_bresp_o,
	output reg         s_axi_bvalid_o,
	input  wire        s_axi_bready_i,
	output reg         wr_go_o,
	output reg  [5:0]  wr_addr_o,
	output reg  [15:0] wr_data_o,
	output reg  [1:0]  wr_strb_o,
	input  wire        wr_hit_i
);

	reg aw_held_q;
	reg w_held_q;

	always @(posedge clk_sys_i)
	begin
		if (srst_i)
		begin
			s_axi_awready_o <= 1'b1;
			s_axi_wready_o  <= 1'b1;
			s_axi_bvalid_o  <= 1'b0;
			s_axi_bresp_o   <= `GAC_RESP_OKAY;
			aw_held_q       <= 1'b0;
			w_held_q        <= 1'b0;
			wr_go_o         <= 1'b0;
			wr_addr_o       <= `GAC_ADDR_RST;
			wr_data_o       <= `GAC_DATA_RST;
			wr_strb_o       <= `GAC_STRB_RST;
		end
		else
		begin
			wr_go_o <= 1'b0;
			if (s_axi_awvalid_i && s_axi_awready_o)
			begin
				wr_addr_o       <= s_axi_awaddr_i;
				aw_held_q       <= 1'b1;
				s_axi_awready_o <= 1'b0;
			end
			if (s_axi_wvalid_i && s_axi_wready_o)
			begin
				wr_data_o      <= s_axi_wdata_i[15:0];
				wr_strb_o      <= s_axi_wstrb_i[1:0];
				w_held_q       <= 1'b1;
				s_axi_wready_o <= 1'b0;
			end
			if (aw_held_q && w_held_q && !s_axi_bvalid_o && !wr_go_o)
				wr_go_o <= 1'b1;
			if (wr_go_o)
			begin
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o  <= wr_hit_i ? `GAC_RESP_OKAY : `GAC_RESP_SLVERR;
				aw_held_q      <= 1'b0;
				w_held_q       <= 1'b0;
			end
			if (s_axi_bvalid_o && s_axi_bready_i)
			begin
				s_axi_bvalid_o  <= 1'b0;
				s_axi_awready_o <= 1'b1;
				s_axi_wready_o  <= 1'b1;
			end
		end
	end

endmodule
`default_nettype wire

//--- core/gac_channel.v
`default_nettype none
`include "gac_consts.vh"

// One amplifier channel: control and trim registers plus decoded analog controls.
module gac_channel
(
	input  wire        clk_sys_i,
	input  wire        srst_i,
	input  wire        ctrl_we_i,
	input  wire        trim_we_i,
	input  wire [15:0] wdata_i,
	input  wire [1:0]  wstrb_i,
	output wire [15:0] ctrl_o,
	output wire [15:0] trim_o,
	output reg         amp_enable_o,
	output reg  [2:0]  pos_input_sel_o,
	output reg         neg_ref_sel_o,
	output reg  [2:0]  gain_code_o,
	output reg  [5:0]  offset_trim_o
);

	reg  [15:0] ctrl_q;
	reg  [15:0] trim_q;
	wire [15:0] lane_mask;
	wire [15:0] ctrl_d;
	wire [15:0] trim_d;

	assign lane_mask = {{8{wstrb_i[1]}}, {8{wstrb_i[0]}}};
	assign ctrl_d = ((ctrl_q & ~lane_mask) | (wdata_i & lane_mask)) & `GAC_CTRL_MASK;
	assign trim_d = ((trim_q & ~lane_mask) | (wdata_i & lane_mask)) & `GAC_TRIM_MASK;

	always @(posedge clk_sys_i)
	begin
		if (srst_i)
		begin
			ctrl_q <= `GAC_CTRL_RST;
			trim_q <= `GAC_TRIM_RST;
		end
		else
		begin
			if (ctrl_we_i)
				ctrl_q <= ctrl_d;
			if (trim_we_i)
				trim_q <= trim_d;
		end
	end

	assign ctrl_o = ctrl_q;
	assign trim_o = trim_q;

	// Reserved codes are not passed on: the analog side sees a safe default
	// instead, so a stray write cannot drive an undefined mux setting.
	always @(posedge clk_sys_i)
	begin
		if (srst_i)
		begin
			amp_enable_o    <= 1'b0;
			pos_input_sel_o <= `GAC_PSEL_A;
			neg_ref_sel_o   <= 1'b0;
			gain_code_o     <= `GAC_GAIN_4;
			offset_trim_o   <= `GAC_TRIM_OUT_RST;
		end
		else
		begin
			amp_enable_o <= ctrl_q[`GAC_EN_BIT];
			if (ctrl_q[`GAC_PSEL_HI:`GAC_PSEL_LO] <= `GAC_PSEL_C)
				pos_input_sel_o <= ctrl_q[`GAC_PSEL_HI:`GAC_PSEL_LO];
			else
				pos_input_sel_o <= `GAC_PSEL_A;
			neg_ref_sel_o <= (ctrl_q[`GAC_NSEL_HI:`GAC_NSEL_LO] == `GAC_NSEL_REF);
			if (ctrl_q[`GAC_GAIN_HI:`GAC_GAIN_LO] >= `GAC_GAIN_4 &&
				ctrl_q[`GAC_GAIN_HI:`GAC_GAIN_LO] <= `GAC_GAIN_64)
				gain_code_o <= ctrl_q[`GAC_GAIN_HI:`GAC_GAIN_LO];
			else
				gain_code_o <= `GAC_GAIN_4;
			offset_trim_o <= trim_q[`GAC_TRIM_HI:`GAC_TRIM_LO];
		end
	end

endmodule
`default_nettype wire

//--- core/gac_consts.vh
`ifndef GAC_CONSTS_VH
`define GAC_CONSTS_VH

// Register byte addresses. Each register takes one aligned 32-bit word.
`define GAC_ADDR_W          6
`define GAC_OFS_CTRL_ONE    6'h00
`define GAC_OFS_TRIM_ONE    6'h04
`define GAC_OFS_CTRL_TWO    6'h08
`define GAC_OFS_TRIM_TWO    6'h0C

// Control register fields.
`define GAC_EN_BIT          15
`define GAC_PSEL_HI         13
`define GAC_PSEL_LO         11
`define GAC_NSEL_HI         10
`define GAC_NSEL_LO         8
`define GAC_GAIN_HI         2
`define GAC_GAIN_LO         0
`define GAC_CTRL_MASK       16'hBF07

// Calibration register fields.
`define GAC_TRIM_HI         5
`define GAC_TRIM_LO         0
`define GAC_TRIM_MASK       16'h003F

// Reset values.
`define GAC_CTRL_RST        16'h0000
`define GAC_TRIM_RST        16'h0000
`define GAC_TRIM_OUT_RST    6'h00
`define GAC_ADDR_RST        6'h00
`define GAC_DATA_RST        16'h0000
`define GAC_STRB_RST        2'h0
`define GAC_RDATA_RST       32'h00000000
`define GAC_RD_PAD          16'h0000

// Field codes.
`define GAC_PSEL_A          3'h0
`define GAC_PSEL_B          3'h1
`define GAC_PSEL_C          3'h2
`define GAC_NSEL_GND        3'h0
`define GAC_NSEL_REF        3'h1
`define GAC_NSEL_GND_ALT    3'h3
`define GAC_GAIN_4          3'h2
`define GAC_GAIN_64         3'h6

// Bus responses.
`define GAC_RESP_OKAY       2'h0
`define GAC_RESP_SLVERR     2'h2

`endif

//--- core/gac_regs_top.v
`default_nettype none
`include "gac_consts.vh"

module gac_regs_top
(
	input  wire        clk_sys_i,
	input  wire        srst_i,
	input  wire [5:0]  s_axi_awaddr_i,
	input  wire [2:0]  s_axi_awprot_i,
	input  wire        s_axi_awvalid_i,
	output wire        s_axi_awready_o,
	input  wire [31:0] s_axi_wdata_i,
	input  wire [3:0]  s_axi_wstrb_i,
	input  wire        s_axi_wvalid_i,
	output wire        s_axi_wready_o,
	output wire [1:0]  s_axi_bresp_o,
	output wire        s_axi_bvalid_o,
	input  wire        s_axi_bready_i,
	input  wire [5:0]  s_axi_araddr_i,
	input  wire [2:0]  s_axi_arprot_i,
	input  wire        s_axi_arvalid_i,
	output reg         s_axi_arready_o,
	output reg  [31:0] s_axi_rdata_o,
	output reg  [1:0]  s_axi_rresp_o,
	output reg         s_axi_rvalid_o,
	input  wire        s_axi_rready_i,
	output wire [1:0]  amp_enable_o,
	output wire [5:0]  pos_input_sel_o,
	output wire [1:0]  neg_ref_sel_o,
	output wire [5:0]  gain_code_o,
	output wire [11:0] offset_trim_o
);

	// ----------------------------------------------------------------
	// Write path
	// ----------------------------------------------------------------
	wire        wr_go;
	wire [5:0]  wr_addr;
	wire [15:0] wr_data;
	wire [1:0]  wr_strb;
	reg         wr_hit;
	wire [15:0] ctrl_rd [0:1];
	wire [15:0] trim_rd [0:1];

	always @*
	begin
		case (wr_addr)
			`GAC_OFS_CTRL_ONE,
			`GAC_OFS_TRIM_ONE,
			`GAC_OFS_CTRL_TWO,
			`GAC_OFS_TRIM_TWO: wr_hit = 1'b1;
			default:           wr_hit = 1'b0;
		endcase
	end

	gac_axil_slave u_wr
	(
		.clk_sys_i       (clk_sys_i),
		.srst_i          (srst_i),
		.s_axi_awaddr_i  (s_axi_awaddr_i),
		.s_axi_awvalid_i (s_axi_awvalid_i),
		.s_axi_awready_o (s_axi_awready_o),
		.s_axi_wdata_i   (s_axi_wdata_i),
		.s_axi_wstrb_i   (s_axi_wstrb_i),
		.s_axi_wvalid_i  (s_axi_wvalid_i),
		.s_axi_wready_o  (s_axi_wready_o),
		.s_axi_bresp_o   (s_axi_bresp_o),
		.s_axi_bvalid_o  (s_axi_bvalid_o),
		.s_axi_bready_i  (s_axi_bready_i),
		.wr_go_o         (wr_go),
		.wr_addr_o       (wr_addr),
		.wr_data_o       (wr_data),
		.wr_strb_o       (wr_strb),
		.wr_hit_i        (wr_hit)
	);

	// ----------------------------------------------------------------
	// Channels
	// ----------------------------------------------------------------
	// two identical channels
	gac_channel u_ch_one
	(
		.clk_sys_i       (clk_sys_i),
		.srst_i          (srst_i),
		.ctrl_we_i       (wr_go && wr_addr == `GAC_OFS_CTRL_ONE),
		.trim_we_i       (wr_go && wr_addr == `GAC_OFS_TRIM_ONE),
		.wdata_i         (wr_data),
		.wstrb_i         (wr_strb),
		.ctrl_o          (ctrl_rd[0]),
		.trim_o          (trim_rd[0]),
		.amp_enable_o    (amp_enable_o[0]),
		.pos_input_sel_o (pos_input_sel_o[2:0]),
		.neg_ref_sel_o   (neg_ref_sel_o[0]),
		.gain_code_o     (gain_code_o[2:0]),
		.offset_trim_o   (offset_trim_o[5:0])
	);

	gac_channel u_ch_two
	(
		.clk_sys_i       (clk_sys_i),
		.srst_i          (srst_i),
		.ctrl_we_i       (wr_go && wr_addr == `GAC_OFS_CTRL_TWO),
		.trim_we_i       (wr_go && wr_addr == `GAC_OFS_TRIM_TWO),
		.wdata_i         (wr_data),
		.wstrb_i         (wr_strb),
		.ctrl_o          (ctrl_rd[1]),
		.trim_o          (trim_rd[1]),
		.amp_enable_o    (amp_enable_o[1]),
		.pos_input_sel_o (pos_input_sel_o[5:3]),
		.neg_ref_sel_o   (neg_ref_sel_o[1]),
		.gain_code_o     (gain_code_o[5:3]),
		.offset_trim_o   (offset_trim_o[11:6])
	);

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	// Reads are not gated by the channel enable: software must be able to
	// verify the trim it loaded before it turns a channel on.
	reg [15:0] rd_val;
	reg        rd_hit;

	always @*
	begin
		rd_val = `GAC_DATA_RST;
		rd_hit = 1'b1;
		case (s_axi_araddr_i)
			`GAC_OFS_CTRL_ONE: rd_val = ctrl_rd[0];
			`GAC_OFS_TRIM_ONE: rd_val = trim_rd[0];
			`GAC_OFS_CTRL_TWO: rd_val = ctrl_rd[1];
			`GAC_OFS_TRIM_TWO: rd_val = trim_rd[1];
			default:           rd_hit = 1'b0;
		endcase
	end

	always @(posedge clk_sys_i)
	begin
		if (srst_i)
		begin
			s_axi_arready_o <= 1'b1;
			s_axi_rvalid_o  <= 1'b0;
			s_axi_rdata_o   <= `GAC_RDATA_RST;
			s_axi_rresp_o   <= `GAC_RESP_OKAY;
		end
		else if (s_axi_arvalid_i && s_axi_arready_o)
		begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o  <= 1'b1;
			s_axi_rdata_o   <= {`GAC_RD_PAD, rd_val};
			s_axi_rresp_o   <= rd_hit ? `GAC_RESP_OKAY : `GAC_RESP_SLVERR;
		end
		else if (s_axi_rvalid_o && s_axi_rready_i)
		begin
			s_axi_rvalid_o  <= 1'b0;
			s_axi_arready_o <= 1'b1;
		end
	end

endmodule
`default_nettype wire

//--- tb/gac_regs_properties.sv
`default_nettype none

module gac_regs_properties
(
	input wire logic        clk_sys_i,
	input wire logic        srst_i,
	input wire logic        s_axi_awvalid_i,
	input wire logic        s_axi_awready_o,
	input wire logic        s_axi_wvalid_i,
	input wire logic        s_axi_wready_o,
	input wire logic        s_axi_bvalid_o,
	input wire logic [5:0]  s_axi_araddr_i,
	input wire logic        s_axi_arvalid_i,
	input wire logic        s_axi_arready_o,
	input wire logic [31:0] s_axi_rdata_o,
	input wire logic [1:0]  s_axi_rresp_o,
	input wire logic        s_axi_rvalid_o,
	input wire logic [1:0]  amp_enable_o,
	input wire logic [5:0]  pos_input_sel_o,
	input wire logic [5:0]  gain_code_o,
	input wire logic [11:0] offset_trim_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (srst_i);

	// Analog controls may only move right after a register write lands.
	a_en_cause: assert property (
		$changed(amp_enable_o) |-> $past(s_axi_bvalid_o)) else $error("enable moved without write");
	a_trim_cause: assert property (
		$changed(offset_trim_o) |-> $past(s_axi_bvalid_o)) else $error("trim moved without write");
	a_pos_legal: assert property (
		pos_input_sel_o[2:0] <= 3'h2 && pos_input_sel_o[5:3] <= 3'h2) else $error("bad pos select");
	a_gain_legal: assert property (
		gain_code_o[2:0] inside {[3'h2:3'h6]} && gain_code_o[5:3] inside {[3'h2:3'h6]})
		else $error("bad gain code");
	a_rd_zero_bits: assert property (
		s_axi_rvalid_o |-> (s_axi_rdata_o & 32'hFFFF40C0) == 32'h0) else $error("unused bits set");
	a_reset_clear: assert property (
		$fell(srst_i) |-> amp_enable_o == 2'h0 && offset_trim_o == 12'h000 && gain_code_o == 6'h12)
		else $error("outputs not cleared");
	a_unmapped_rd: assert property (
		s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i > 6'h0C
		|=> s_axi_rresp_o == 2'h2 && s_axi_rdata_o == 32'h0) else $error("unmapped read answered");
	a_rd_next: assert property (
		s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o) else $error("read answer late");
	a_wr_answer: assert property (
		s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
		|-> ##[1:3] s_axi_bvalid_o) else $error("write answer late");
endmodule

bind gac_regs_top gac_regs_properties u_props (.clk_sys_i, .srst_i, .s_axi_awvalid_i,
	.s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_araddr_i,
	.s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
	.amp_enable_o, .pos_input_sel_o, .gain_code_o, .offset_trim_o);

`default_nettype wire

//--- tb/tb.sv
`default_nettype none
`include "gac_consts.vh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin num_errors++; \
	$display("[ERR] %s exp %h got %h", nm, e, g); end end

module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_sys_i = 1'b0;
	logic        srst_i = 1'b1;
	logic [5:0]  aw_a = '0, ar_a = '0;
	logic [31:0] w_d = '0;
	logic [3:0]  w_s = '0;
	logic        aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0;
	wire         aw_rdy, w_rdy, b_v, ar_rdy, r_v;
	wire  [1:0]  b_resp, r_resp, en_o, nref_o;
	wire  [31:0] r_d;
	wire  [5:0]  psel_o, gain_o;
	wire  [11:0] trim_o;
	int          num_errors = 0, compares = 0, cyc = 0;
	logic [15:0] mdl [4];
	logic [1:0]  resp;
	logic [31:0] rv;

	gac_regs_top dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .s_axi_awaddr_i(aw_a),
		.s_axi_awprot_i(3'h0), .s_axi_awvalid_i(aw_v), .s_axi_awready_o(aw_rdy),
		.s_axi_wdata_i(w_d), .s_axi_wstrb_i(w_s), .s_axi_wvalid_i(w_v), .s_axi_wready_o(w_rdy),
		.s_axi_bresp_o(b_resp), .s_axi_bvalid_o(b_v), .s_axi_bready_i(b_r),
		.s_axi_araddr_i(ar_a), .s_axi_arprot_i(3'h0), .s_axi_arvalid_i(ar_v),
		.s_axi_arready_o(ar_rdy), .s_axi_rdata_o(r_d), .s_axi_rresp_o(r_resp),
		.s_axi_rvalid_o(r_v), .s_axi_rready_i(r_r), .amp_enable_o(en_o),
		.pos_input_sel_o(psel_o), .neg_ref_sel_o(nref_o), .gain_code_o(gain_o),
		.offset_trim_o(trim_o));

	always #10 clk_sys_i = ~clk_sys_i;

	task automatic test_done();
		$display("compares %0d errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// A hung handshake is cut short here and counted as a mismatch.
	always @(posedge clk_sys_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			num_errors++;
			test_done();
		end
	end

	task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] r);
		@(posedge clk_sys_i);
		aw_a <= a;
		w_d <= d;
		w_s <= s;
		aw_v <= 1'b1;
		w_v <= 1'b1;
		b_r <= 1'b1;
		forever
		begin
			@(posedge clk_sys_i);
			if (aw_v && aw_rdy)
				aw_v <= 1'b0;
			if (w_v && w_rdy)
				w_v <= 1'b0;
			if (b_v === 1'b1)
				break;
		end
		r = b_resp;
		b_r <= 1'b0;
	endtask

	task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk_sys_i);
		ar_a <= a;
		ar_v <= 1'b1;
		r_r <= 1'b1;
		forever
		begin
			@(posedge clk_sys_i);
			if (ar_v && ar_rdy)
				ar_v <= 1'b0;
			if (r_v === 1'b1)
				break;
		end
		d = r_d;
		r = r_resp;
		r_r <= 1'b0;
	endtask

	function automatic logic [15:0] msk(input int i, input logic [15:0] d);
		return d & ((i % 2) ? `GAC_TRIM_MASK : `GAC_CTRL_MASK);
	endfunction

	// Reserved selector codes fall back to the safe defaults on the outputs.
	task automatic chk_all();
		logic [15:0] c;
		for (int k = 0; k < 4; k++)
		begin
			rd(6'(k * 4), rv, resp);
			`CHK("rdata", {16'h0000, mdl[k]}, rv)
			`CHK("rresp", `GAC_RESP_OKAY, resp)
		end
		for (int ch = 0; ch < 2; ch++)
		begin
			c = mdl[ch * 2];
			`CHK("enable", c[15], en_o[ch])
			`CHK("pos_sel", (c[13:11] > 3'h2) ? 3'h0 : c[13:11], psel_o[ch * 3 +: 3])
			`CHK("neg_ref", c[10:8] == `GAC_NSEL_REF, nref_o[ch])
			`CHK("gain", (c[2:0] < 3'h2 || c[2:0] > 3'h6) ? 3'h2 : c[2:0], gain_o[ch * 3 +: 3])
			`CHK("trim", mdl[ch * 2 + 1][5:0], trim_o[ch * 6 +: 6])
		end
	endtask

	task automatic put(input int i, input logic [15:0] d, input logic [3:0] s,
		input logic [1:0] er);
		logic [15:0] m;
		m = msk(i, d);
		wr(6'(i * 4), {16'h0000, d}, s, resp);
		`CHK("bresp", er, resp)
		for (int b = 0; b < 2; b++)
			if (i < 4 && s[b])
				mdl[i][b * 8 +: 8] = m[b * 8 +: 8];
		chk_all();
	endtask

	initial
	begin
		void'($urandom(32'hEAB4));
		foreach (mdl[k])
			mdl[k] = 16'h0000;
		repeat (3) @(posedge clk_sys_i);
		srst_i <= 1'b0;
		chk_all();
		for (int c = 0; c < 8; c++)
		begin
			put(c % 2 * 2 + 1, 16'(c * 9 + 16'hFFC0), 4'h3, `GAC_RESP_OKAY);
			put(c % 2 * 2, {c[1], 1'b1, 3'(c), 3'(c), 5'h1F, 3'(c)}, 4'h3, `GAC_RESP_OKAY);
		end
		for (int n = 0; n < 24; n++)
			put($urandom_range(3), 16'($urandom), 4'($urandom), `GAC_RESP_OKAY);
		put(4, 16'hFFFF, 4'hF, `GAC_RESP_SLVERR);
		rd(6'h10, rv, resp);
		`CHK("rresp", `GAC_RESP_SLVERR, resp)
		`CHK("rdata", 32'h0, rv)
		@(posedge clk_sys_i);
		srst_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		srst_i <= 1'b0;
		foreach (mdl[k])
			mdl[k] = 16'h0000;
		chk_all();
		test_done();
	end
endmodule

`default_nettype wire
